// *** common/flpm_pkg.sv ***
// Package for the FIFO level and power management register bank.
// Assumes a 100 MHz system clock and a 32-bit host register port.
package flpm_pkg;
  localparam logic [7:0] RX_LEVEL_OFS = 8'h7c;
  localparam logic [7:0] TX_LEVEL_OFS = 8'h80;
  localparam logic [7:0] PMCTRL_OFS = 8'h84;
  localparam logic [7:0] BYTE_TEST_OFS = 8'h64;
  localparam int STATUS_LSB = 16;
  localparam int MODE_LSB = 12;
  localparam int PHYRST_BIT = 10;
  localparam int LANWAKE_BIT = 9;
  localparam int ENWAKE_BIT = 8;
  localparam int DRIVER_BIT = 6;
  localparam int CAUSE_LSB = 4;
  localparam int PULSE_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int OUTEN_BIT = 1;
  localparam int READY_BIT = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] RX_DATA_RST = 16'h0000;
  localparam logic [15:0] TX_FREE_RST = 16'h1200;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam int CLK_MHZ = 100;
  localparam int PHY_RESET_REQUEST_US = 100;
  localparam int PHY_RESET_REQUEST_CYC = PHY_RESET_REQUEST_US * CLK_MHZ;
  localparam int WAKE_PULSE_MS = 50;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    FLPM_D0 = 2'b00,
    FLPM_D1 = 2'b01,
    FLPM_D2 = 2'b10,
    FLPM_DRSV = 2'b11
  } flpm_mode_t;
endpackage

// *** verilog/flpm_timer.sv ***
// Down counter that holds a busy level for a fixed number of cycles.
// Start is a one-cycle pulse; restart while busy reloads the count.
`timescale 1ns/100ps
module flpm_timer #(
  parameter int CYCLES = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o
);
  typedef struct packed {
    logic [31:0] cnt;
  } flpm_tmr_t;
  flpm_tmr_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (start_i) begin
      s_d.cnt = 32'(CYCLES);
    end else if (s_q.cnt != 32'h0) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign busy_o = (s_q.cnt != 32'h0);
endmodule

// *** verilog/flpm_wake_out.sv ***
// Wake output shaping: driver type, polarity, pulse or static form.
// Assumes event pulse and clear from the register bank.
`timescale 1ns/100ps
module flpm_wake_out #(
  parameter int PULSE_CYC = 5000000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic active_static_i,
  input wire logic pulse_sel_i,
  input wire logic enable_i,
  input wire logic driver_sel_i,
  input wire logic polarity_i,
  output logic wake_o,
  output logic wake_oe_o
);
  logic pulse_busy;
  logic active;
  flpm_timer #(.CYCLES(PULSE_CYC)) u_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(event_i & pulse_sel_i),
    .busy_o(pulse_busy)
  );
  assign active = enable_i & (pulse_sel_i ? pulse_busy : active_static_i);
  always_comb begin
    if (!driver_sel_i) begin
      wake_o = 1'b0;
      wake_oe_o = active;
    end else begin
      wake_o = polarity_i ? active : ~active;
      wake_oe_o = 1'b1;
    end
  end
endmodule

// *** verilog/flpm_regs.sv ***
// FIFO level and power management registers.
// Assumes a synchronous SRAM-like host port and FIFO level inputs from the datapath.
// Overview of operation
// - Receive level bits 23-16 show receive status FIFO used dwords, reset 00h.
// - Receive level bits 15-0 show receive data bytes used, frames rounded to dwords.
// - Transmit level bits 23-16 show transmit status FIFO used dwords, reset 00h.
// - Transmit level bits 15-0 show free transmit data bytes, reset 1200h.
// - Power management control stays readable in every reduced power state.
// - Mode field bits 13-12: normal, frame wake, energy; self-clearing; 11b never written.
// - A write to byte test register, once a read has been seen since sleep, wakes the device from reduced power.
// - Writing 1 to bit 10 resets PHY for 100us, then bit clears itself.
// - Writes to the PHY reset bit are ignored while it reads high.
// - Bit 9 lets frame wake events drive wake output and always wake interrupt.
// - Bit 8 lets energy events drive wake output and always wake interrupt.
// - Bit 6 clear gives open-drain active-low output; set gives push-pull.
// - Bit 0 reads 1 when the device is ready for access.
// - Pulse select gives 50 ms pulses, else static until wake cause cleared.
// - Bit 1 enables the external wake output only, not the interrupt.
`timescale 1ns/100ps
module flpm_regs #(
  parameter int PHY_RESET_REQUEST_CYC = flpm_pkg::PHY_RESET_REQUEST_CYC,
  parameter int WAKE_PULSE_CYC = flpm_pkg::WAKE_PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [7:0] rx_status_used_dwords_i,
  input wire logic [15:0] rx_data_used_bytes_i,
  input wire logic [7:0] tx_status_used_dwords_i,
  input wire logic [15:0] tx_data_free_bytes_i,
  input wire logic lan_wake_event_i,
  input wire logic energy_wake_event_i,
  input wire logic wake_ready_i,
  output logic [1:0] power_state_o,
  output logic phy_reset_o,
  output logic device_ready_o,
  output logic wake_interrupt_o,
  output logic wake_event_out_o,
  output logic wake_event_oe_o
);
  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] state;
    logic [1:0] mode_field;
    logic lan_en;
    logic energy_en;
    logic driver_sel;
    logic pulse_sel;
    logic polarity;
    logic out_en;
    logic [1:0] cause;
    logic read_seen;
    logic phy_start;
  } flpm_state_t;
  flpm_state_t s_q, s_d;
  logic phy_busy;
  logic ready;
  logic wr_ok;
  logic pm_wr;
  logic lan_hit;
  logic energy_hit;
  logic wake_pulse;
  logic [31:0] pm_word;

  flpm_timer #(.CYCLES(PHY_RESET_REQUEST_CYC)) u_phy_reset_request (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(s_q.phy_start),
    .busy_o(phy_busy)
  );

  flpm_wake_out #(.PULSE_CYC(WAKE_PULSE_CYC)) u_wake (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .event_i(wake_pulse),
    .active_static_i(s_q.cause != 2'h0),
    .pulse_sel_i(s_q.pulse_sel),
    .enable_i(s_q.out_en),
    .driver_sel_i(s_q.driver_sel),
    .polarity_i(s_q.polarity),
    .wake_o(wake_event_out_o),
    .wake_oe_o(wake_event_oe_o)
  );

  assign ready = (s_q.state == flpm_pkg::FLPM_D0) && (s_q.mode_field == flpm_pkg::MODE_RST);
  assign wr_ok = reg_wr_i && s_q.read_seen;
  assign pm_wr = wr_ok && ready && (reg_addr_i == flpm_pkg::PMCTRL_OFS);
  assign lan_hit = lan_wake_event_i && s_q.lan_en;
  assign energy_hit = energy_wake_event_i && s_q.energy_en;
  assign wake_pulse = lan_hit || energy_hit;

  always_comb begin
    pm_word = 32'h0;
    pm_word[flpm_pkg::MODE_LSB +: 2] = s_q.mode_field;
    pm_word[flpm_pkg::PHYRST_BIT] = s_q.phy_start | phy_busy;
    pm_word[flpm_pkg::LANWAKE_BIT] = s_q.lan_en;
    pm_word[flpm_pkg::ENWAKE_BIT] = s_q.energy_en;
    pm_word[flpm_pkg::DRIVER_BIT] = s_q.driver_sel;
    pm_word[flpm_pkg::CAUSE_LSB +: 2] = s_q.cause;
    pm_word[flpm_pkg::PULSE_BIT] = s_q.pulse_sel;
    pm_word[flpm_pkg::POL_BIT] = s_q.polarity;
    pm_word[flpm_pkg::OUTEN_BIT] = s_q.out_en;
    pm_word[flpm_pkg::READY_BIT] = ready;
  end

  always_comb begin
    s_d = s_q;
    s_d.phy_start = 1'b0;
    if (reg_rd_i) begin
      s_d.read_seen = 1'b1;
      s_d.rdata = 32'h0;
      case (reg_addr_i)
        flpm_pkg::RX_LEVEL_OFS: begin
          if (ready) begin
            s_d.rdata[flpm_pkg::STATUS_LSB +: 8] = rx_status_used_dwords_i;
            s_d.rdata[15:0] = rx_data_used_bytes_i;
          end
        end
        flpm_pkg::TX_LEVEL_OFS: begin
          if (ready) begin
            s_d.rdata[flpm_pkg::STATUS_LSB +: 8] = tx_status_used_dwords_i;
            s_d.rdata[15:0] = tx_data_free_bytes_i;
          end
        end
        flpm_pkg::PMCTRL_OFS: begin
          s_d.rdata = pm_word;
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
    if (pm_wr) begin
      s_d.lan_en = reg_wdata_i[flpm_pkg::LANWAKE_BIT];
      s_d.energy_en = reg_wdata_i[flpm_pkg::ENWAKE_BIT];
      s_d.driver_sel = reg_wdata_i[flpm_pkg::DRIVER_BIT];
      s_d.pulse_sel = reg_wdata_i[flpm_pkg::PULSE_BIT];
      s_d.polarity = reg_wdata_i[flpm_pkg::POL_BIT];
      s_d.out_en = reg_wdata_i[flpm_pkg::OUTEN_BIT];
      s_d.cause = s_q.cause & ~reg_wdata_i[flpm_pkg::CAUSE_LSB +: 2];
      if (reg_wdata_i[flpm_pkg::PHYRST_BIT] && !(s_q.phy_start || phy_busy)) begin
        s_d.phy_start = 1'b1;
      end
      if (reg_wdata_i[flpm_pkg::MODE_LSB +: 2] != 2'(flpm_pkg::FLPM_DRSV) &&
          reg_wdata_i[flpm_pkg::MODE_LSB +: 2] != 2'(flpm_pkg::FLPM_D0)) begin
        s_d.mode_field = reg_wdata_i[flpm_pkg::MODE_LSB +: 2];
        s_d.state = reg_wdata_i[flpm_pkg::MODE_LSB +: 2];
        s_d.read_seen = 1'b0;
      end
    end
    if (energy_hit) begin
      s_d.cause[0] = 1'b1;
    end
    if (lan_hit) begin
      s_d.cause[1] = 1'b1;
    end
    if (s_q.state != flpm_pkg::FLPM_D0) begin
      if ((wr_ok && reg_addr_i == flpm_pkg::BYTE_TEST_OFS) || wake_pulse) begin
        s_d.state = flpm_pkg::FLPM_D0;
        s_d.read_seen = 1'b0;
      end
    end else if (s_q.mode_field != flpm_pkg::MODE_RST && wake_ready_i) begin
      s_d.mode_field = flpm_pkg::MODE_RST;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign power_state_o = s_q.state;
  assign phy_reset_o = s_q.phy_start | phy_busy;
  assign device_ready_o = ready;
  assign wake_interrupt_o = s_q.cause != 2'h0;

  a_phy_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(phy_reset_o) |-> phy_reset_o [*8]) else $error("PHY reset released early");
  a_phy_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    phy_busy |-> !s_d.phy_start) else $error("PHY reset restarted while high");
  a_mode_legal: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_q.mode_field != 2'h3) else $error("Reserved power mode");
  a_no_early_wr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_wr_i && !s_q.read_seen) |=> $stable(s_q.lan_en)) else $error("Write before read honoured");
  a_byte_wake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_ok && reg_addr_i == flpm_pkg::BYTE_TEST_OFS && s_q.state != 2'h0) |=> s_q.state == 2'h0)
    else $error("Byte test write did not wake");
  a_wake_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lan_hit |=> wake_interrupt_o) else $error("Wake interrupt missing");
  a_energy_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    energy_hit |=> s_q.cause[0]) else $error("Energy cause missing");
  a_open_drain: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !s_q.driver_sel |-> !wake_event_out_o) else $error("Open drain drove high");
  a_pm_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == flpm_pkg::PMCTRL_OFS) |=> reg_rdata_o[13:12] == $past(s_q.mode_field))
    else $error("Power control read wrong");
  a_tx_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && ready && reg_addr_i == flpm_pkg::TX_LEVEL_OFS) |=>
    reg_rdata_o == {8'h0, $past(tx_status_used_dwords_i), $past(tx_data_free_bytes_i)})
    else $error("Transmit level read wrong");
  a_rx_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && ready && reg_addr_i == flpm_pkg::RX_LEVEL_OFS) |=>
    reg_rdata_o == {8'h0, $past(rx_status_used_dwords_i), $past(rx_data_used_bytes_i)})
    else $error("Receive level read wrong");
  a_level_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && !ready && (reg_addr_i == flpm_pkg::RX_LEVEL_OFS || reg_addr_i == flpm_pkg::TX_LEVEL_OFS))
    |=> reg_rdata_o == 32'h0) else $error("Level read while not ready");
  a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i != flpm_pkg::RX_LEVEL_OFS && reg_addr_i != flpm_pkg::TX_LEVEL_OFS &&
    reg_addr_i != flpm_pkg::PMCTRL_OFS) |=> reg_rdata_o == 32'h0) else $error("Unmapped read not zero");
  a_pm_reserved: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == flpm_pkg::PMCTRL_OFS) |=> (reg_rdata_o & 32'hffffc880) == 32'h0)
    else $error("Reserved power control bits set");
  a_pm_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == flpm_pkg::PMCTRL_OFS) |=> reg_rdata_o[flpm_pkg::READY_BIT] == $past(device_ready_o))
    else $error("Ready bit read wrong");
  a_phy_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == flpm_pkg::PMCTRL_OFS) |=> reg_rdata_o[flpm_pkg::PHYRST_BIT] == $past(phy_reset_o))
    else $error("PHY reset bit read wrong");
  a_phy_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::PHYRST_BIT] && !phy_reset_o) |=> phy_reset_o)
    else $error("PHY reset not started");
  a_sleep_frame: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::MODE_LSB +: 2] == 2'h1) |=> power_state_o == 2'h1 && !device_ready_o)
    else $error("Frame wake mode not entered");
  a_sleep_energy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::MODE_LSB +: 2] == 2'h2) |=> power_state_o == 2'h2 && !device_ready_o)
    else $error("Energy mode not entered");
  a_mode_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && (reg_wdata_i[flpm_pkg::MODE_LSB +: 2] == 2'h0 || reg_wdata_i[flpm_pkg::MODE_LSB +: 2] == 2'h3))
    |=> power_state_o == 2'h0 && s_q.mode_field == 2'h0) else $error("Mode write not ignored");
  a_mode_self_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (power_state_o == 2'h0 && s_q.mode_field != 2'h0 && wake_ready_i) |=> s_q.mode_field == 2'h0)
    else $error("Mode field did not clear");
  a_mode_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (power_state_o == 2'h0 && s_q.mode_field != 2'h0 && !wake_ready_i) |=> $stable(s_q.mode_field))
    else $error("Mode field cleared early");
  a_sleep_stay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (power_state_o != 2'h0 && !wake_pulse && !(wr_ok && reg_addr_i == flpm_pkg::BYTE_TEST_OFS))
    |=> $stable(power_state_o)) else $error("Left reduced power without cause");
  a_event_wake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (power_state_o != 2'h0 && wake_pulse) |=> power_state_o == 2'h0)
    else $error("Wake event did not wake");
  a_event_rearm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (power_state_o != 2'h0 && wake_pulse) |=> !s_q.read_seen)
    else $error("Read not required after wake");
  a_read_arms: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && power_state_o == 2'h0 && !pm_wr) |=> s_q.read_seen)
    else $error("Read did not enable writes");
  a_sleep_rearm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::MODE_LSB +: 2] != 2'h0 && reg_wdata_i[flpm_pkg::MODE_LSB +: 2] != 2'h3)
    |=> !s_q.read_seen) else $error("Read not required after sleep");
  a_byte_rearm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_ok && reg_addr_i == flpm_pkg::BYTE_TEST_OFS && power_state_o != 2'h0) |=> !s_q.read_seen)
    else $error("Read not required after byte wake");
  a_lan_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lan_hit |=> s_q.cause[1])
    else $error("Frame cause missing");
  a_cause_stable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!pm_wr && !wake_pulse) |=> $stable(s_q.cause))
    else $error("Wake cause changed without event");
  a_energy_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::CAUSE_LSB] && !energy_hit) |=> !s_q.cause[0])
    else $error("Energy cause not cleared");
  a_lan_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pm_wr && reg_wdata_i[flpm_pkg::CAUSE_LSB + 1] && !lan_hit) |=> !s_q.cause[1])
    else $error("Frame cause not cleared");
  a_irq_unmasked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ((lan_hit || energy_hit) && !s_q.out_en) |=> wake_interrupt_o)
    else $error("Interrupt masked by output enable");
  a_out_disabled: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !s_q.out_en |-> (s_q.driver_sel ? wake_event_out_o == !s_q.polarity : !wake_event_oe_o))
    else $error("Disabled wake output active");
  a_static_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.out_en && !s_q.pulse_sel && !s_q.driver_sel && s_q.cause != 2'h0) |-> wake_event_oe_o)
    else $error("Static wake output missing");
  a_static_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.out_en && !s_q.pulse_sel && !s_q.driver_sel && s_q.cause == 2'h0) |-> !wake_event_oe_o)
    else $error("Static wake output stuck");
  a_pulse_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wake_pulse && !pm_wr && s_q.pulse_sel && s_q.out_en && !s_q.driver_sel) |=> wake_event_oe_o)
    else $error("Wake pulse not started");
  a_push_oe: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_q.driver_sel |-> wake_event_oe_o)
    else $error("Push-pull driver not enabled");
  a_push_polarity: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.driver_sel && s_q.out_en && !s_q.pulse_sel) |-> wake_event_out_o == ((s_q.cause != 2'h0) == s_q.polarity))
    else $error("Push-pull polarity wrong");
  a_ctrl_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !pm_wr |=> $stable({s_q.lan_en, s_q.energy_en, s_q.driver_sel, s_q.pulse_sel, s_q.polarity, s_q.out_en}))
    else $error("Control bits changed without write");
  c_phy_reset: cover property (@(posedge clk_sys_i) $fell(phy_reset_o));
  c_sleep_wake: cover property (@(posedge clk_sys_i) $fell(s_q.state == 2'h1));
  c_wake_pin: cover property (@(posedge clk_sys_i) wake_event_oe_o);
  c_pulse_end: cover property (@(posedge clk_sys_i) $fell(wake_event_oe_o));
  c_energy_mode: cover property (@(posedge clk_sys_i) power_state_o == 2'h2);
endmodule

// *** tb/flpm_host.sv ***
// Host model for the register port: single 32-bit reads and writes.
// Assumes the bench calls rd and wr; strobes change only after rising edges.
`timescale 1ns/100ps
module flpm_host (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic device_ready_i,
  input wire logic [31:0] rdata_i,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o
);
  bit armed = 1'b0;
  initial {rd_o, wr_o, addr_o, wdata_o} = '0;
  always @(posedge clk_sys_i) if (rst_i) armed = 1'b0;
  // No data-FIFO push port exists here, so the free count is never overrun
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
    armed = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit raw = 1'b0);
    logic [31:0] t;
    int n;
    n = 0;
    while (!raw && a != flpm_pkg::BYTE_TEST_OFS && device_ready_i !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 100) begin
      flpm_regs_test.err_count++;
      flpm_regs_test.final_report();
    end
    if (a == flpm_pkg::PMCTRL_OFS && d[13:12] == 2'b11) d[13:12] = 2'b00;
    if (!raw && !armed) rd(flpm_pkg::PMCTRL_OFS, t);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    #1;
    if (a == flpm_pkg::BYTE_TEST_OFS || (a == flpm_pkg::PMCTRL_OFS && d[13:12] != 2'b00)) armed = 1'b0;
  endtask
endmodule

// *** tb/flpm_regs_test.sv ***
// Self-checking bench for the FIFO level and power management registers.
// Assumes the host model drives the port; short timer parameters.
`timescale 1ns/100ps
module flpm_regs_test;
  localparam int PHY_CYC = 20;
  localparam int PULSE_CYC = 30;
  localparam logic [7:0] PM = flpm_pkg::PMCTRL_OFS;
  localparam logic [7:0] RX = flpm_pkg::RX_LEVEL_OFS;
  localparam logic [7:0] TX = flpm_pkg::TX_LEVEL_OFS;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd, wr, ready, phy_reset_request, irq, wout, woe;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] rx_sts = 8'h00, tx_sts = 8'h00;
  logic [15:0] rx_dat = 16'h0000, tx_free = 16'h1200;
  logic lan_ev = 1'b0, en_ev = 1'b0, wake_rdy = 1'b0;
  logic [1:0] pstate;
  int err_count = 0, total_checks = 0, phy_cnt = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (phy_reset_request === 1'b1) phy_cnt++;
  flpm_regs #(.PHY_RESET_REQUEST_CYC(PHY_CYC), .WAKE_PULSE_CYC(PULSE_CYC)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .rx_status_used_dwords_i(rx_sts), .rx_data_used_bytes_i(rx_dat), .tx_status_used_dwords_i(tx_sts),
    .tx_data_free_bytes_i(tx_free), .lan_wake_event_i(lan_ev), .energy_wake_event_i(en_ev),
    .wake_ready_i(wake_rdy), .power_state_o(pstate), .phy_reset_o(phy_reset_request), .device_ready_o(ready),
    .wake_interrupt_o(irq), .wake_event_out_o(wout), .wake_event_oe_o(woe));
  flpm_host i_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .device_ready_i(ready), .rdata_i(rdata),
    .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    i_host.rd(a, v);
    chk(name, v, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pulse_ev(input bit lan);
    @(posedge clk_sys_i);
    lan_ev <= lan;
    en_ev <= !lan;
    @(posedge clk_sys_i);
    lan_ev <= 1'b0;
    en_ev <= 1'b0;
    tick(3);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    i_host.wr(PM, 32'h00000200, 1'b1);
    rchk(PM, 32'h00000001, "pm reset");
    rchk(RX, 32'h00000000, "rx reset");
    rchk(TX, 32'h00001200, "tx reset");
    rchk(8'h88, 32'h00000000, "unmapped");
    $display("test reset done");
    @(posedge clk_sys_i);
    rx_sts <= 8'h5a;
    rx_dat <= 16'h0124;
    tx_sts <= 8'h81;
    tx_free <= 16'h0ffc;
    i_host.wr(RX, 32'hffffffff);
    i_host.wr(TX, 32'hffffffff);
    i_host.wr(PM, 32'hffffc880);
    rchk(RX, 32'h005a0124, "rx level");
    rchk(TX, 32'h00810ffc, "tx level");
    rchk(PM, 32'h00000001, "pm reserved");
    $display("test levels done");
    phy_cnt = 0;
    i_host.wr(PM, 32'h00000400);
    i_host.wr(PM, 32'h00000000);
    rchk(PM, 32'h00000401, "phy bit held");
    for (int i = 0; i < 100 && phy_reset_request === 1'b1; i++) tick(1);
    if (phy_reset_request !== 1'b0) begin
      err_count++;
      final_report();
    end
    chk("phy hold", phy_cnt, PHY_CYC + 1);
    rchk(PM, 32'h00000001, "phy bit clear");
    $display("test phy reset done");
    i_host.wr(PM, 32'h00000246);
    pulse_ev(1'b1);
    tick(PULSE_CYC + 5);
    chk("irq lan", irq, 1'b1);
    chk("push pull out", {woe, wout}, 2'b11);
    rchk(PM, 32'h00000267, "cause lan");
    i_host.wr(PM, 32'h00000266);
    tick(3);
    chk("irq cleared", irq, 1'b0);
    chk("push pull idle", {woe, wout}, 2'b10);
    i_host.wr(PM, 32'h00000242);
    chk("active low idle", {woe, wout}, 2'b11);
    pulse_ev(1'b1);
    chk("active low on", {woe, wout}, 2'b10);
    i_host.wr(PM, 32'h00000262);
    i_host.wr(PM, 32'h00000108);
    pulse_ev(1'b0);
    chk("irq energy", irq, 1'b1);
    chk("out disabled", woe, 1'b0);
    rchk(PM, 32'h00000119, "cause energy");
    i_host.wr(PM, 32'h0000011e);
    pulse_ev(1'b0);
    chk("open drain on", {woe, wout}, 2'b10);
    tick(PULSE_CYC + 5);
    chk("pulse ended", woe, 1'b0);
    chk("irq held", irq, 1'b1);
    i_host.wr(PM, 32'h0000011a);
    tick(3);
    chk("irq clear", irq, 1'b0);
    $display("test wake output done");
    for (int m = 1; m < 3; m++) begin
      i_host.wr(PM, 32'(m) << 12);
      tick(1);
      chk("state asleep", pstate, m);
      chk("ready asleep", ready, 1'b0);
      rchk(PM, 32'(m) << 12, "pm asleep");
      rchk(RX, 32'h00000000, "level asleep");
      i_host.wr(flpm_pkg::BYTE_TEST_OFS, 32'h00000000);
      tick(1);
      chk("state woken", pstate, 2'b00);
      chk("ready waiting", ready, 1'b0);
      @(posedge clk_sys_i);
      wake_rdy <= 1'b1;
      tick(3);
      chk("ready back", ready, 1'b1);
      @(posedge clk_sys_i);
      wake_rdy <= 1'b0;
      rchk(PM, 32'h00000001, "mode cleared");
    end
    i_host.wr(PM, 32'h00001100);
    tick(1);
    chk("energy asleep", pstate, 2'b01);
    pulse_ev(1'b0);
    chk("energy woken", pstate, 2'b00);
    chk("energy not ready", ready, 1'b0);
    @(posedge clk_sys_i);
    wake_rdy <= 1'b1;
    @(posedge clk_sys_i);
    wake_rdy <= 1'b0;
    tick(2);
    rchk(PM, 32'h00000111, "energy cause");
    i_host.wr(PM, 32'h00000010);
    rchk(PM, 32'h00000001, "energy cleared");
    $display("test power states done");
    i_host.wr(PM, 32'h00000200);
    rchk(PM, 32'h00000201, "lan enable set");
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    i_host.wr(PM, 32'h00000200, 1'b1);
    rchk(PM, 32'h00000001, "pm after reset");
    $display("test mid-run reset done");
    final_report();
  end
endmodule
